// ==== inc/gpio_port_pkg.sv ====
/*
  Constants and carrier types for the 17-pin general purpose I/O port.
  Assumes AXI4-Lite register access with 32-bit data words; register
  indices are multiplied by four to form byte addresses.
*/
// How it works
// [R1] Low input register reads pins 15..0
// [R2] High input bit0 reads pin 16, rest zero
// [R3] Low output latch drives pins 15..0
// [R4] High output bit0 latch drives pin 16
// [R5] Output registers read latch, not pins
// [R6] Set-level strobe ones force latch bits high
// [R7] Low clear-level strobe ones clear low latch
// [R8] High clear-level bit0 clears pin 16 latch
// [R9] Zero bits in strobes change nothing
// [R10] Low direction latch enables pins 15..0 drivers
// [R11] High direction bit0 enables pin 16 driver
// [R12] Low direction-set ones set direction bits
// [R13] High direction-set bit0 enables pin 16
// [R14] Config: 15-bit field, bit15 zero, bit13 resets one
// [R15] Config resets to only bit 13 set
// [R16] Low direction-clear ones clear direction bits
// [R17] Driver off unless direction bit set
// [R18] Strobes read zero, act on write cycle
package gpio_port_pkg;

  // ******************************
  // Geometry
  // ******************************
  localparam int PIN_COUNT = 17;
  localparam int LOW_PINS  = 16;
  localparam int CFG_W     = 15;
  localparam int ADDR_W    = 18;

  // ******************************
  // Register indices (byte address = index * 4)
  // ******************************
  localparam logic [15:0] IDX_PIN_INPUT_HIGH      = 16'h4700;
  localparam logic [15:0] IDX_PIN_INPUT_LOW       = 16'h4702;
  localparam logic [15:0] IDX_OUTPUT_LEVEL_HIGH   = 16'h4704;
  localparam logic [15:0] IDX_OUTPUT_LEVEL_LOW    = 16'h4706;
  localparam logic [15:0] IDX_LEVEL_SET_HIGH      = 16'h4708;
  localparam logic [15:0] IDX_LEVEL_SET_LOW       = 16'h470A;
  localparam logic [15:0] IDX_LEVEL_CLEAR_HIGH    = 16'h470C;
  localparam logic [15:0] IDX_LEVEL_CLEAR_LOW     = 16'h470E;
  localparam logic [15:0] IDX_PIN_FUNCTION_CONFIG = 16'h4712;
  localparam logic [15:0] IDX_DIRECTION_HIGH      = 16'h4714;
  localparam logic [15:0] IDX_DIRECTION_LOW       = 16'h4716;
  localparam logic [15:0] IDX_DIRECTION_SET_HIGH  = 16'h4718;
  localparam logic [15:0] IDX_DIRECTION_SET_LOW   = 16'h471A;
  localparam logic [15:0] IDX_DIRECTION_CLEAR_LOW = 16'h471E;

  // ******************************
  // Reset values and bus answers
  // ******************************
  localparam logic [16:0] LEVEL_RESET = 17'h00000;
  localparam logic [16:0] DIR_RESET   = 17'h00000;
  localparam logic [14:0] CFG_RESET   = 15'h2000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ******************************
  // Pin drive carrier
  // ******************************
  typedef struct packed {
    logic [16:0] level;
    logic [16:0] enable;
  } pin_drive_s;

endpackage

// ==== hdl/gpio_data_direction_port.sv ====
/*
  GPIO data and direction port: input sampling, output level latches
  with set/clear strobes, direction latches with set strobes and a clear strobe for pins 15..0 only, and
  the pin function configuration field, all behind an AXI4-Lite slave.
  Assumes pins are asynchronous to mclk and that pad logic resolves
  the wire level from pin_drive (level, enable).
  Assumes a master that holds each request until it is taken:
    write - address and data in either order; the latches change at
            the edge that raises bvalid, one edge after the later one
    read  - data are captured at the edge that takes the address
    pins  - an input register shows a pin change two edges late
  One write and one read at most are outstanding at a time.
  Alternate pin functions are left to logic outside this block.
*/
`timescale 1ns/10ps
`default_nettype none
module gpio_data_direction_port (
  input  wire logic                                mclk,
  input  wire logic                                reset,
  input  wire logic                                awvalid,
  output logic                                     awready,
  input  wire logic [gpio_port_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic [2:0]                          awprot,
  input  wire logic                                wvalid,
  output logic                                     wready,
  input  wire logic [31:0]                         wdata,
  input  wire logic [3:0]                          wstrb,
  output logic                                     bvalid,
  input  wire logic                                bready,
  output logic [1:0]                               bresp,
  input  wire logic                                arvalid,
  output logic                                     arready,
  input  wire logic [gpio_port_pkg::ADDR_W-1:0]    araddr,
  input  wire logic [2:0]                          arprot,
  output logic                                     rvalid,
  input  wire logic                                rready,
  output logic [31:0]                              rdata,
  output logic [1:0]                               rresp,
  input  wire logic [gpio_port_pkg::PIN_COUNT-1:0] pin_in,
  output gpio_port_pkg::pin_drive_s                pin_drive,
  output logic [gpio_port_pkg::CFG_W-1:0]          pin_function_config
);
  import gpio_port_pkg::*;

  // ******************************
  // Pin input synchroniser
  // ******************************
  // Not reset: pins read the same in and out of reset, and two
  // reset edges flush any stale level before software can look.
  // A late settle in stage one costs a cycle of lag, never a glitch.
  logic [16:0] pin_meta_q;
  logic [16:0] pin_sync_q;

  // Two stages; only pin_sync_q is read by logic
  always_ff @(posedge mclk) begin
    pin_meta_q <= pin_in;
    pin_sync_q <= pin_meta_q;
  end

  // ******************************
  // Write channel state
  // ******************************
  // Held request and handshake flops
  logic              aw_full_q;
  logic              w_full_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;

  // Handshake terms and next values
  logic aw_take;
  logic w_take;
  logic do_write;
  logic aw_full_d;
  logic w_full_d;
  logic bvalid_d;

  // Address and data are accepted in either order, then paired
  // The pair is applied one edge after both are held, so the
  // latches never act on half a request; the cost is one cycle
  // of write latency, hidden behind the response handshake
  assign aw_take   = awvalid & awready_q;
  assign w_take    = wvalid & wready_q;
  assign do_write  = aw_full_q & w_full_q;
  assign aw_full_d = (aw_full_q | aw_take) & ~do_write;
  assign w_full_d  = (w_full_q | w_take) & ~do_write;
  assign bvalid_d  = do_write | (bvalid_q & ~bready);

  // ******************************
  // Write decode
  // ******************************
  // Register selects, at most one high per applied write
  logic [15:0] widx;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic        wr_in_hi;
  logic        wr_in_lo;
  logic        wr_out_hi;
  logic        wr_out_lo;
  logic        wr_set_hi;
  logic        wr_set_lo;
  logic        wr_clr_hi;
  logic        wr_clr_lo;
  logic        wr_cfg;
  logic        wr_dir_hi;
  logic        wr_dir_lo;
  logic        wr_dset_hi;
  logic        wr_dset_lo;
  logic        wr_dclr_lo;
  logic        wr_mapped;

  // Only the low two byte lanes carry register bits
  assign widx  = waddr_q[17:2];
  assign wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wval  = wdata_q[15:0] & wmask;

  // Index compares gated by the applying pulse
  assign wr_in_hi   = do_write & (widx == IDX_PIN_INPUT_HIGH);
  assign wr_in_lo   = do_write & (widx == IDX_PIN_INPUT_LOW);
  assign wr_out_hi  = do_write & (widx == IDX_OUTPUT_LEVEL_HIGH);
  assign wr_out_lo  = do_write & (widx == IDX_OUTPUT_LEVEL_LOW);

  // Level strobes
  assign wr_set_hi  = do_write & (widx == IDX_LEVEL_SET_HIGH);
  assign wr_set_lo  = do_write & (widx == IDX_LEVEL_SET_LOW);
  assign wr_clr_hi  = do_write & (widx == IDX_LEVEL_CLEAR_HIGH);
  assign wr_clr_lo  = do_write & (widx == IDX_LEVEL_CLEAR_LOW);

  // Config, direction latches and direction strobes
  assign wr_cfg     = do_write & (widx == IDX_PIN_FUNCTION_CONFIG);
  assign wr_dir_hi  = do_write & (widx == IDX_DIRECTION_HIGH);
  assign wr_dir_lo  = do_write & (widx == IDX_DIRECTION_LOW);
  assign wr_dset_hi = do_write & (widx == IDX_DIRECTION_SET_HIGH);
  assign wr_dset_lo = do_write & (widx == IDX_DIRECTION_SET_LOW);
  assign wr_dclr_lo = do_write & (widx == IDX_DIRECTION_CLEAR_LOW);

  // Writes to the input registers are mapped but change nothing
  assign wr_mapped = wr_in_hi |
                     wr_in_lo |
                     wr_out_hi |
                     wr_out_lo |
                     wr_set_hi |
                     wr_set_lo |
                     wr_clr_hi |
                     wr_clr_lo |
                     wr_cfg |
                     wr_dir_hi |
                     wr_dir_lo |
                     wr_dset_hi |
                     wr_dset_lo |
                     wr_dclr_lo;

  // ******************************
  // Latch next values
  // ******************************
  // Latched state and next values
  pin_drive_s        pin_q;
  logic [CFG_W-1:0]  cfg_q;
  logic [16:0]       level_d;
  logic [16:0]       dir_d;
  logic [CFG_W-1:0]  cfg_d;

  // Merge terms for plain writes and strobes
  logic [16:0]       level_rw;
  logic [16:0]       dir_rw;
  logic [14:0]       cfg_rw;
  logic [16:0]       level_set;
  logic [16:0]       level_clr;
  logic [16:0]       dir_set;
  logic [16:0]       dir_clr;

  // Plain writes merge through the byte lanes
  assign level_rw[15:0] = wr_out_lo ? ((pin_q.level[15:0] & ~wmask) | wval)
                                    : pin_q.level[15:0];                // R3
  assign level_rw[16]   = (wr_out_hi & wstrb_q[0]) ? wdata_q[0]
                                                   : pin_q.level[16];   // R4
  assign dir_rw[15:0]   = wr_dir_lo ? ((pin_q.enable[15:0] & ~wmask) | wval)
                                    : pin_q.enable[15:0];               // R10
  assign dir_rw[16]     = (wr_dir_hi & wstrb_q[0]) ? wdata_q[0]
                                                   : pin_q.enable[16];  // R11
  assign cfg_rw = wr_cfg ? ((cfg_q & ~wmask[14:0]) | wval[14:0]) : cfg_q; // R14

  // Strobes act only where a one was written
  assign level_set = {wr_set_hi & wval[0], wr_set_lo ? wval : 16'h0000}; // R6 R9
  assign level_clr = {wr_clr_hi & wval[0], wr_clr_lo ? wval : 16'h0000}; // R7 R8 R9
  assign dir_set   = {wr_dset_hi & wval[0], wr_dset_lo ? wval : 16'h0000}; // R12 R13
  assign dir_clr   = {1'b0, wr_dclr_lo ? wval : 16'h0000};             // R16 R9

  // Set before clear; one write reaches one register only, so
  // no single write can both set and clear the same bit
  assign level_d = (level_rw | level_set) & ~level_clr;
  assign dir_d   = (dir_rw | dir_set) & ~dir_clr;
  assign cfg_d   = cfg_rw;

  // Latches feed the pads directly so the strobe lands this edge
  // Synchronous reset only: every reset value is a constant
  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_q.level  <= LEVEL_RESET;
      pin_q.enable <= DIR_RESET;
    end else begin
      pin_q.level  <= level_d;                                        // R18
      pin_q.enable <= dir_d;                                          // R17
    end
  end

  // Config is only stored and exported; pin functions are not applied
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_q <= CFG_RESET;                                             // R15
    end else begin
      cfg_q <= cfg_d;                                                 // R14
    end
  end

  // ******************************
  // Write channel handshake
  // ******************************
  // Channels stall while a response is pending, one write at a time
  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q  <= ~w_full_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
    end
  end

  // Address held from its handshake until the pair is applied
  always_ff @(posedge mclk) begin
    if (reset) begin
      waddr_q <= '0;
    end else if (aw_take) begin
      waddr_q <= awaddr;
    end
  end

  // Data and lane strobes held the same way
  always_ff @(posedge mclk) begin
    if (reset) begin
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (w_take) begin
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end
  end

  // Response code fixed at the applying edge; unmapped gets an error
  always_ff @(posedge mclk) begin
    if (reset) begin
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ******************************
  // Read decode
  // ******************************
  // Read selects, decoded from araddr held with arvalid
  logic [15:0] ridx;
  logic        rd_in_hi;
  logic        rd_in_lo;
  logic        rd_out_hi;
  logic        rd_out_lo;
  logic        rd_cfg;
  logic        rd_dir_hi;
  logic        rd_dir_lo;
  logic        rd_strobe;
  logic        rd_mapped;
  logic [15:0] rd_word;

  assign ridx      = araddr[17:2];
  // One compare per readable register
  assign rd_in_hi  = (ridx == IDX_PIN_INPUT_HIGH);
  assign rd_in_lo  = (ridx == IDX_PIN_INPUT_LOW);
  assign rd_out_hi = (ridx == IDX_OUTPUT_LEVEL_HIGH);
  assign rd_out_lo = (ridx == IDX_OUTPUT_LEVEL_LOW);
  assign rd_cfg    = (ridx == IDX_PIN_FUNCTION_CONFIG);
  assign rd_dir_hi = (ridx == IDX_DIRECTION_HIGH);
  assign rd_dir_lo = (ridx == IDX_DIRECTION_LOW);

  // Strobe registers are write-only and answer zero
  assign rd_strobe = (ridx == IDX_LEVEL_SET_HIGH) | (ridx == IDX_LEVEL_SET_LOW) |
                     (ridx == IDX_LEVEL_CLEAR_HIGH) | (ridx == IDX_LEVEL_CLEAR_LOW) |
                     (ridx == IDX_DIRECTION_SET_HIGH) |
                     (ridx == IDX_DIRECTION_SET_LOW) |
                     (ridx == IDX_DIRECTION_CLEAR_LOW);                // R18
  assign rd_mapped = rd_in_hi |
                     rd_in_lo |
                     rd_out_hi |
                     rd_out_lo |
                     rd_cfg |
                     rd_dir_hi |
                     rd_dir_lo |
                     rd_strobe;

  // Output registers show the latch, which may differ from the pad
  // Unused bits are forced low so no stale state is exposed
  assign rd_word = ({16{rd_in_lo}}  & pin_sync_q[15:0])                 // R1
                 | ({16{rd_in_hi}}  & {15'h0000, pin_sync_q[16]})       // R2
                 | ({16{rd_out_lo}} & pin_q.level[15:0])                // R5
                 | ({16{rd_out_hi}} & {15'h0000, pin_q.level[16]})      // R4
                 | ({16{rd_dir_lo}} & pin_q.enable[15:0])               // R10
                 | ({16{rd_dir_hi}} & {15'h0000, pin_q.enable[16]})     // R11
                 | ({16{rd_cfg}}    & {1'b0, cfg_q});                   // R14

  // ******************************
  // Read channel handshake
  // ******************************
  // Read response flops
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        ar_take;
  logic        rvalid_d;

  assign ar_take  = arvalid & arready_q;
  assign rvalid_d = ar_take | (rvalid_q & ~rready);

  // arready falls while rvalid waits, so one read at most is open
  always_ff @(posedge mclk) begin
    if (reset) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
    end
  end

  // Data captured at the address edge; saves a wait state per read
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      rdata_q <= {16'h0000, rd_word};
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ******************************
  // Outputs
  // ******************************
  // Every output is a flop, so the bus and pads see no decode glitch
  // and the checker can sample them at any edge
  assign awready             = awready_q;
  assign wready              = wready_q;
  assign bvalid              = bvalid_q;
  assign bresp               = bresp_q;
  assign arready             = arready_q;
  assign rvalid              = rvalid_q;
  assign rdata               = rdata_q;
  assign rresp               = rresp_q;
  assign pin_drive           = pin_q;                                   // R17
  assign pin_function_config = cfg_q;

endmodule // gpio_data_direction_port
`default_nettype wire

// ==== test/gpio_port_properties.sv ====
/*
  Checker for the GPIO port: bus handshakes, reset state and pin outputs.
  Assumes it is bound to gpio_data_direction_port and sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none
module gpio_port_properties
  import gpio_port_pkg::*;
(
  input wire logic                       mclk,
  input wire logic                       reset,
  input wire logic                       awvalid,
  input wire logic                       awready,
  input wire logic                       wvalid,
  input wire logic                       wready,
  input wire logic                       bvalid,
  input wire logic                       bready,
  input wire logic [1:0]                 bresp,
  input wire logic                       arvalid,
  input wire logic                       arready,
  input wire logic                       rvalid,
  input wire logic                       rready,
  input wire logic [31:0]                rdata,
  input wire gpio_port_pkg::pin_drive_s  pin_drive,
  input wire logic [14:0]                pin_function_config
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // ******************************
  // Bus answers
  // ******************************
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  rdata_upper_a: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  write_answer_a: assert property (
    awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write answer timing wrong");
  write_busy_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  read_busy_a: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");

  // ******************************
  // Latches move only on reset or a write
  // ******************************
  reset_state_a: assert property (disable iff (1'b0)
    reset |=> pin_function_config == CFG_RESET && pin_drive == '0)
    else $error("reset state wrong");
  drive_quiet_a: assert property (!$stable(pin_drive) |-> $rose(bvalid) || $past(reset))
    else $error("pin drive moved without a write");
  config_quiet_a: assert property (
    !$stable(pin_function_config) |-> $rose(bvalid) || $past(reset))
    else $error("config moved without a write");
endmodule  // gpio_port_properties

bind gpio_data_direction_port gpio_port_properties gpio_port_properties_i (
  .mclk(mclk), .reset(reset), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .pin_drive(pin_drive),
  .pin_function_config(pin_function_config));
`default_nettype wire

// ==== test/gpio_pad_model.sv ====
/*
  Pad model: the outside world behind the 17 port pins.
  Assumes ext comes from the bench and pin_drive from the port.
*/
`timescale 1ns/10ps
`default_nettype none
module gpio_pad_model
  import gpio_port_pkg::*;
(
  input  wire gpio_port_pkg::pin_drive_s pin_drive,
  input  wire logic [16:0]               ext,
  output logic [16:0]                    pin_in
);
  // Enabled driver wins; otherwise the far device sets the level
  assign pin_in = (pin_drive.level & pin_drive.enable) | (ext & ~pin_drive.enable);
endmodule  // gpio_pad_model
`default_nettype wire

// ==== test/gpio_data_direction_port_test.sv ====
/*
  Self-checking bench for the GPIO port over AXI4-Lite.
  Assumes the pad model resolves pins and the checker is bound.
*/
`timescale 1ns/10ps
`default_nettype none
module gpio_data_direction_port_test;
  import gpio_port_pkg::*;
  logic        mclk = 1'b0;
  logic        reset, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [16:0] pin_in, ext, lvl, dir;
  logic [14:0] pin_function_config, cfg;
  pin_drive_s  pin_drive;
  int          fails, checked, k;
  logic [15:0] tab [15];

  gpio_data_direction_port gpio_data_direction_port_i (
    .mclk(mclk), .reset(reset), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .pin_in(pin_in), .pin_drive(pin_drive),
    .pin_function_config(pin_function_config));
  gpio_pad_model gpio_pad_model_i (.pin_drive(pin_drive), .ext(ext), .pin_in(pin_in));

  always #12.5 mclk = ~mclk;

  // ******************************
  // Reporting and bus tasks
  // ******************************
  task automatic check(input string what, input logic [33:0] s, input logic [33:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Address and data offered together, each released when taken
  task automatic wr(input logic [15:0] idx, input logic [31:0] dv, input logic [3:0] s);
    bit done;
    done = 0;
    @(posedge mclk);
    awaddr <= {idx, 2'b00};
    wdata <= dv;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rsp = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) begin
      fails++;
      final_report();
    end
  endtask
  task automatic rd(input logic [15:0] idx);
    bit done;
    done = 0;
    @(posedge mclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        rsp = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) begin
      fails++;
      final_report();
    end
  endtask

  // ******************************
  // Expected behaviour
  // ******************************
  function automatic logic [1:0] exp_resp(input logic [15:0] idx);
    return (idx == 16'h4710) ? RESP_SLVERR : RESP_OKAY;
  endfunction
  function automatic logic [31:0] exp_rd(input logic [15:0] idx);
    logic [16:0] p;
    p = (lvl & dir) | (ext & ~dir);
    case (idx)
      IDX_PIN_INPUT_HIGH:      return {31'h0, p[16]};
      IDX_PIN_INPUT_LOW:       return {16'h0, p[15:0]};
      IDX_OUTPUT_LEVEL_HIGH:   return {31'h0, lvl[16]};
      IDX_OUTPUT_LEVEL_LOW:    return {16'h0, lvl[15:0]};
      IDX_PIN_FUNCTION_CONFIG: return {17'h0, cfg};
      IDX_DIRECTION_HIGH:      return {31'h0, dir[16]};
      IDX_DIRECTION_LOW:       return {16'h0, dir[15:0]};
      default:                 return 32'h0;
    endcase
  endfunction
  // Lanes switched off by wstrb leave bits alone
  task automatic step(input logic [15:0] idx, input logic [31:0] dv, input logic [3:0] s);
    logic [15:0] m;
    logic [15:0] dm;
    m = {{8{s[1]}}, {8{s[0]}}};
    dm = dv[15:0] & m;
    wr(idx, dv, s);
    case (idx)
      IDX_OUTPUT_LEVEL_HIGH:   lvl[16] = m[0] ? dv[0] : lvl[16];
      IDX_OUTPUT_LEVEL_LOW:    lvl[15:0] = (lvl[15:0] & ~m) | dm;
      IDX_LEVEL_SET_HIGH:      lvl[16] = lvl[16] | dm[0];
      IDX_LEVEL_SET_LOW:       lvl[15:0] = lvl[15:0] | dm;
      IDX_LEVEL_CLEAR_HIGH:    lvl[16] = lvl[16] & ~dm[0];
      IDX_LEVEL_CLEAR_LOW:     lvl[15:0] = lvl[15:0] & ~dm;
      IDX_PIN_FUNCTION_CONFIG: cfg = (cfg & ~m[14:0]) | dm[14:0];
      IDX_DIRECTION_HIGH:      dir[16] = m[0] ? dv[0] : dir[16];
      IDX_DIRECTION_LOW:       dir[15:0] = (dir[15:0] & ~m) | dm;
      IDX_DIRECTION_SET_HIGH:  dir[16] = dir[16] | dm[0];
      IDX_DIRECTION_SET_LOW:   dir[15:0] = dir[15:0] | dm;
      IDX_DIRECTION_CLEAR_LOW: dir[15:0] = dir[15:0] & ~dm;
      default: ;
    endcase
    check("bresp", 34'(rsp), 34'(exp_resp(idx)));
    check("level", 34'(pin_drive.level), 34'(lvl));
    check("enable", 34'(pin_drive.enable), 34'(dir));
    check("config", 34'(pin_function_config), 34'(cfg));
  endtask
  task automatic read_check(input int i);
    rd(tab[i]);
    check("rdata", 34'(d), 34'(exp_rd(tab[i])));
    check("rresp", 34'(rsp), 34'(exp_resp(tab[i])));
  endtask

  // ******************************
  // Main sequence
  // ******************************
  initial begin
    {reset, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, wstrb, ext} = '0;
    {lvl, dir, cfg} = {LEVEL_RESET, DIR_RESET, CFG_RESET};
    {fails, checked} = 0;
    tab = '{IDX_PIN_INPUT_HIGH, IDX_PIN_INPUT_LOW, IDX_OUTPUT_LEVEL_HIGH,
            IDX_OUTPUT_LEVEL_LOW, IDX_LEVEL_SET_HIGH, IDX_LEVEL_SET_LOW,
            IDX_LEVEL_CLEAR_HIGH, IDX_LEVEL_CLEAR_LOW, IDX_PIN_FUNCTION_CONFIG,
            IDX_DIRECTION_HIGH, IDX_DIRECTION_LOW, IDX_DIRECTION_SET_HIGH,
            IDX_DIRECTION_SET_LOW, IDX_DIRECTION_CLEAR_LOW, 16'h4710};
    k = $urandom(92123);
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 15; i++) read_check(i);
    // Corners: zero strobe bits, masked lanes, upper bits ignored
    step(IDX_DIRECTION_LOW, 32'h0000FFFF, 4'hF);
    step(IDX_OUTPUT_LEVEL_LOW, 32'h0000A5A5, 4'hF);
    step(IDX_LEVEL_CLEAR_LOW, 32'h0000FF0F, 4'h1);
    step(IDX_LEVEL_CLEAR_HIGH, 32'h0000FFFE, 4'hF);
    step(IDX_LEVEL_SET_HIGH, 32'h00000001, 4'h1);
    step(IDX_DIRECTION_SET_HIGH, 32'h00000001, 4'h1);
    step(IDX_DIRECTION_HIGH, 32'h0000FFFF, 4'hF);
    step(IDX_PIN_FUNCTION_CONFIG, 32'hFFFFFFFF, 4'hF);
    step(IDX_PIN_INPUT_LOW, 32'h00001234, 4'hF);
    step(16'h4710, 32'h0000FFFF, 4'hF);
    step(IDX_LEVEL_SET_LOW, 32'h00000F00, 4'h2);
    step(IDX_LEVEL_CLEAR_HIGH, 32'h00000001, 4'h1);
    step(IDX_DIRECTION_CLEAR_LOW, 32'h0000F0F0, 4'hF);
    step(IDX_DIRECTION_SET_LOW, 32'h00003030, 4'h1);
    for (int i = 0; i < 15; i++) read_check(i);
    // Random writes and reads with moving far-side pins
    repeat (80) begin
      @(posedge mclk);
      ext <= 17'($urandom);
      k = $urandom_range(14);
      step(tab[k], $urandom, 4'($urandom));
      repeat (3) @(posedge mclk);
      read_check($urandom_range(14));
    end
    // Second reset in mid-run
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    {lvl, dir, cfg} = {LEVEL_RESET, DIR_RESET, CFG_RESET};
    for (int i = 0; i < 15; i++) read_check(i);
    final_report();
  end
endmodule  // gpio_data_direction_port_test
`default_nettype wire
